// file: core/led_seq_pkg.sv
/*
  Constants, register map, state encoding and the state record for the
  LED driver startup and fault sequencer.
  Assumes a 50 MHz system clock and comparator levels from the analog side.
*/
package led_seq_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int CLK_HZ           = 50_000_000;
  localparam int CLK_PER_US       = CLK_HZ / 1_000_000;
  localparam int LOW_OFF_US       = 16000;  // Long low on enable/dimming
  localparam int DETECT_DELAY_US  = 1500;   // LED pin settle before decision
  localparam int SOFTSTART_US     = 16000;  // Soft-start ramp timeout
  localparam int CNT_W            = 20;
  localparam logic [CNT_W-1:0] LOW_OFF_CYCLES =
    CNT_W'(LOW_OFF_US * CLK_PER_US);
  localparam logic [CNT_W-1:0] DETECT_CYCLES =
    CNT_W'(DETECT_DELAY_US * CLK_PER_US);
  localparam logic [CNT_W-1:0] SOFTSTART_CYCLES =
    CNT_W'(SOFTSTART_US * CLK_PER_US);

  // ==========================================================================
  // Channels and synchronised input positions
  localparam int NUM_CH      = 6;
  localparam int S_EN        = 0;
  localparam int S_SUPPLY    = 1;
  localparam int S_GATE      = 2;
  localparam int S_UVP_OK    = 3;
  localparam int S_VOUT93    = 4;
  localparam int S_FREQUENCY_PROGRAM_PIN      = 5;
  localparam int S_CURRENT_REFERENCE_PIN      = 6;
  localparam int S_FAULT_PIN = 7;
  localparam int S_ABOVE_LO  = 8;
  localparam int S_INUSE_LO  = 14;
  localparam int S_REG_LO    = 20;
  localparam int SYNC_W      = 26;

  // ==========================================================================
  // Register map (byte addresses inside a 256-byte window)
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_CONFIG   = 8'h04;
  localparam logic [7:0]  ADDR_STATUS   = 8'h08;
  localparam logic [7:0]  ADDR_CHANNELS = 8'h0c;
  localparam int          CTRL_ENABLE   = 0;
  localparam int          CTRL_KEEP     = 1;
  localparam logic [15:0] CFG_RESET     = 16'h0064;
  localparam int          ST_STATE_LO   = 0;
  localparam int          ST_LATCH      = 4;
  localparam int          ST_FAULT      = 5;
  localparam int          ST_OPENLOOP   = 6;
  localparam int          ST_PIN        = 7;
  localparam int          CH_SHORT_LO   = 8;

  // ==========================================================================
  // State machine and state record
  typedef enum logic [2:0] {
    ST_OFF, ST_GATE, ST_WAIT_DIM, ST_DETECT, ST_SOFTSTART, ST_RUN,
    ST_LATCHED
  } state_e;

  typedef struct packed {
    state_e             state;
    logic [SYNC_W-1:0]  s1;
    logic [SYNC_W-1:0]  s2;
    logic [SYNC_W-1:0]  s3;
    logic [SYNC_W-1:0]  filt;
    logic [CNT_W-1:0]   low_cnt;
    logic [CNT_W-1:0]   det_cnt;
    logic [CNT_W-1:0]   ss_cnt;
    logic [15:0]        pulse_cnt;
    logic               uvp_latch;
    logic               short_fault;
    logic               open_loop;
    logic [NUM_CH-1:0]  in_use;
    logic [NUM_CH-1:0]  shorted;
    logic               gate_pull;
    logic               current_reference_pin_en;
    logic               boost_en;
    logic [NUM_CH-1:0]  sink_en;
    logic               fault_oe;
    logic               ctrl_enable;
    logic               keep_awake;
    logic [15:0]        cfg_thresh;
    logic               wr_pend;
    logic [7:0]         wr_addr;
    logic [31:0]        hrdata;
    logic               hreadyout;
    logic               ss_on;
  } seq_s;

  localparam seq_s SEQ_RESET = '{
    state:       ST_OFF,
    ctrl_enable: 1'b1,
    cfg_thresh:  CFG_RESET,
    hreadyout:   1'b1,
    default:     '0
  };

endpackage

// file: core/led_startup_sequencer.sv
/*
  Startup and fault sequencer for a six-channel LED current-sink driver
  with boost stage, reached over an AHB-Lite register slave.
  Assumes comparator levels arrive asynchronously and are synchronised
  here; the enable/dimming pin and the fault pin are from outside.
  Timers count system clocks, so their accuracy is that of the clock.
  Every comparator level takes about four clocks to reach the filter,
  so the sequencer reacts a few clocks after a level changes.
  A bus write lands at the end of its data phase; a read whose address
  phase falls in that same cycle still returns the old value.
*/
// Implementation choices: the AHB-Lite slave port and the address map.
// What this block does
// - Wake only when enable/dimming is high and supply is above lockout.
// - Boost and LED channels enabled by dimming high, separate from wake; boost here stays on through soft-start at any dimming level.
// - Check output, LED, frequency and current pins before switching.
// - Enable/dimming low over 16 ms shuts the device off completely.
// - On wake pull gate down; at threshold enable current reference.
// - Detection starts when gate is at threshold and dimming is high.
// - Wait about 1.5 ms after LED pins rise above 120 mV.
// - Classify pins: shorted, unused, or in use by voltage comparators.
// - Unused channels stay disabled and out of the regulation loop.
// - Any shorted LED pin withholds soft-start.
// - Pin shorts pull fault low, retry, release at end of detection.
// - Output below one twelfth of overvoltage setting blocks soft-start.
// - Output undervoltage shuts the device down and sets a latch.
// - Latch cleared by supply lockout or enable low over 16 ms.
// - Latch also cleared by dimming low over 16 ms while kept awake.
// - Soft-start begins after detection, fixed 16 ms timer ramp.
// - Soft-start ends on regulation, output at 93%, or timeout.
// - Very short dimming pulses select open loop, else closed loop.
// - In operation dimming high turns enabled sinks on, low turns off.
`timescale 1ns/10ps
module led_startup_sequencer #(
  parameter logic [19:0] OFF_CYCLES       = led_seq_pkg::LOW_OFF_CYCLES,
  parameter logic [19:0] DETECT_TIME      = led_seq_pkg::DETECT_CYCLES,
  parameter logic [19:0] SS_TIME          = led_seq_pkg::SOFTSTART_CYCLES
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        en_dim_pin,
  input  wire logic        supply_above_lockout,
  input  wire logic        gate_at_threshold,
  input  wire logic        vout_above_uvp,
  input  wire logic        vout_above_93pct,
  input  wire logic        frequency_program_pin_fault,
  input  wire logic        current_reference_pin_fault,
  input  wire logic [5:0]  led_above_short,
  input  wire logic [5:0]  led_in_use,
  input  wire logic [5:0]  led_in_regulation,
  input  wire logic        fault_in,
  output logic             fault_out,
  output logic             fault_oe,
  output logic             gate_pull_en,
  output logic             current_reference_en,
  output logic             boost_en,
  output logic [5:0]       sink_en,
  output logic [5:0]       channel_in_loop,
  output logic             anticipatory_boost_control,
  output logic             softstart_active
);

  // ==========================================================================
  // Helpers
  // Accept a new level only when the last two stages agree
  function automatic logic [led_seq_pkg::SYNC_W-1:0] agree(
    input logic [led_seq_pkg::SYNC_W-1:0] old,
    input logic [led_seq_pkg::SYNC_W-1:0] b,
    input logic [led_seq_pkg::SYNC_W-1:0] c
  );
    agree = (b & c) | (old & (b | c));
  endfunction

  // Saturating count toward a limit
  function automatic logic [19:0] sat_inc(
    input logic [19:0] v,
    input logic [19:0] lim
  );
    sat_inc = (v < lim) ? v + 20'h00001 : v;
  endfunction

  // Soft-start decode, shared by the ramp flag and the boost enable
  function automatic logic is_ramp(
    input led_seq_pkg::state_e s
  );
    is_ramp = (s == led_seq_pkg::ST_SOFTSTART);
  endfunction

  // ==========================================================================
  // State
  led_seq_pkg::seq_s q;
  led_seq_pkg::seq_s next_q;
  logic [led_seq_pkg::SYNC_W-1:0] raw;

  assign raw = {led_in_regulation, led_in_use, led_above_short, fault_in,
                current_reference_pin_fault, frequency_program_pin_fault,
                vout_above_93pct, vout_above_uvp, gate_at_threshold,
                supply_above_lockout, en_dim_pin};

  // Outputs come straight from the state record; hresp and fault_out are tied low
  assign hreadyout            = q.hreadyout;
  assign hrdata               = q.hrdata;
  assign hresp                = 1'b0;
  assign fault_out            = 1'b0;
  assign fault_oe             = q.fault_oe;
  assign gate_pull_en         = q.gate_pull;
  assign current_reference_en = q.current_reference_pin_en;
  assign boost_en             = q.boost_en;
  assign sink_en              = q.sink_en;
  assign channel_in_loop      = q.in_use;
  assign anticipatory_boost_control = q.open_loop;
  assign softstart_active     = q.ss_on;

  // ==========================================================================
  // Next-state logic
  always_comb begin
    logic       en;
    logic       supply;
    logic       gate_ok;
    logic       uvp_ok;
    logic       v93;
    logic       pin_fault;
    logic [5:0] above;
    logic [5:0] use_now;
    logic [5:0] in_reg;
    logic       long_low;
    logic       take;
    logic       running;
    // Locals start defined so no path reads a stale value
    long_low  = 1'b0;
    take      = 1'b0;
    running   = 1'b0;
    en        = q.filt[led_seq_pkg::S_EN];
    supply    = q.filt[led_seq_pkg::S_SUPPLY];
    gate_ok   = q.filt[led_seq_pkg::S_GATE];
    uvp_ok    = q.filt[led_seq_pkg::S_UVP_OK];
    v93       = q.filt[led_seq_pkg::S_VOUT93];
    pin_fault = q.filt[led_seq_pkg::S_FREQUENCY_PROGRAM_PIN] | q.filt[led_seq_pkg::S_CURRENT_REFERENCE_PIN];
    above     = q.filt[led_seq_pkg::S_ABOVE_LO +: led_seq_pkg::NUM_CH];
    use_now   = q.filt[led_seq_pkg::S_INUSE_LO +: led_seq_pkg::NUM_CH];
    in_reg    = q.filt[led_seq_pkg::S_REG_LO +: led_seq_pkg::NUM_CH];
    next_q    = q;

    // synchronise inputs
    // Stage one feeds only stage two to keep metastability contained
    // Third stage lets the filter compare two settled samples
    next_q.s1   = raw;
    next_q.s2   = q.s1;
    next_q.s3   = q.s2;
    next_q.filt = agree(q.filt, q.s2, q.s3);

    // long low timer
    // Counts only on the filtered level so glitches never restart it
    // Saturates at the limit so a very long low stays a shutdown
    if (!en) begin
      next_q.low_cnt = sat_inc(q.low_cnt, OFF_CYCLES);
    end else begin
      next_q.low_cnt = '0;
    end
    long_low = !en && (q.low_cnt == OFF_CYCLES);

    // pulse width for loop choice
    // Width measured on each falling edge; saturates at 16 bits
    if (en) begin
      next_q.pulse_cnt = 16'(sat_inc({4'h0, q.pulse_cnt}, 20'h0ffff));
    end else if (q.pulse_cnt != 16'h0000) begin
      next_q.open_loop = (q.pulse_cnt < q.cfg_thresh);
      next_q.pulse_cnt = 16'h0000;
    end

    // ------------------------------------------------------------------------
    // Bus slave: zero wait states, read data loaded in the address phase
    take = hsel && htrans[1] && hready;
    next_q.hreadyout = 1'b1;
    next_q.wr_pend   = take && hwrite;
    if (take) begin
      next_q.wr_addr = haddr[7:0];
    end
    // Write data stands only in the data phase, hence the held address
    if (q.wr_pend) begin
      case (q.wr_addr)
        led_seq_pkg::ADDR_CTRL: begin
          next_q.ctrl_enable = hwdata[led_seq_pkg::CTRL_ENABLE];
          next_q.keep_awake  = hwdata[led_seq_pkg::CTRL_KEEP];
        end
        led_seq_pkg::ADDR_CONFIG: begin
          next_q.cfg_thresh = hwdata[15:0];
        end
        default: begin
          next_q.wr_addr = q.wr_addr;
        end
      endcase
    end
    // Read data loaded now so it stands for the whole data phase
    if (take && !hwrite) begin
      next_q.hrdata = 32'h0000_0000;
      case (haddr[7:0])
        led_seq_pkg::ADDR_CTRL: begin
          next_q.hrdata[led_seq_pkg::CTRL_ENABLE] = q.ctrl_enable;
          next_q.hrdata[led_seq_pkg::CTRL_KEEP]   = q.keep_awake;
        end
        led_seq_pkg::ADDR_CONFIG: begin
          next_q.hrdata[15:0] = q.cfg_thresh;
        end
        led_seq_pkg::ADDR_STATUS: begin
          next_q.hrdata[led_seq_pkg::ST_STATE_LO +: 3] = q.state;
          next_q.hrdata[led_seq_pkg::ST_LATCH]    = q.uvp_latch;
          next_q.hrdata[led_seq_pkg::ST_FAULT]    = q.fault_oe;
          next_q.hrdata[led_seq_pkg::ST_OPENLOOP] = q.open_loop;
          next_q.hrdata[led_seq_pkg::ST_PIN] =
            q.filt[led_seq_pkg::S_FAULT_PIN];
        end
        led_seq_pkg::ADDR_CHANNELS: begin
          next_q.hrdata[led_seq_pkg::NUM_CH-1:0] = q.in_use;
          next_q.hrdata[led_seq_pkg::CH_SHORT_LO +: led_seq_pkg::NUM_CH] =
            q.shorted;
        end
        default: begin
          next_q.hrdata = 32'h0000_0000;
        end
      endcase
    end

    // ------------------------------------------------------------------------
    // latch clear by power cycle
    if (!supply || long_low) begin
      next_q.uvp_latch = 1'b0;
    end

    // Sequencer
    case (q.state)
      led_seq_pkg::ST_OFF: begin
        // wake condition
        // A set latch or a cleared enable bit keeps the device asleep
        if (en && supply && q.ctrl_enable && !q.uvp_latch) begin
          next_q.state = led_seq_pkg::ST_GATE;
        end
      end
      led_seq_pkg::ST_GATE: begin
        // gate to threshold
        // Current reference stays off until the gate is at threshold
        if (gate_ok) begin
          next_q.state = led_seq_pkg::ST_WAIT_DIM;
        end
      end
      led_seq_pkg::ST_WAIT_DIM: begin
        if (en && gate_ok) begin
          next_q.det_cnt = '0;
          next_q.state   = led_seq_pkg::ST_DETECT;
        end
      end
      led_seq_pkg::ST_DETECT: begin
        if ((above != 6'h3f) || pin_fault) begin
          next_q.short_fault = 1'b1;
          next_q.shorted     = ~above;
          next_q.det_cnt     = '0;
        end else begin
          next_q.det_cnt = sat_inc(q.det_cnt, DETECT_TIME);
          if (q.det_cnt == DETECT_TIME) begin
            // drop unused channels
            // Classes sampled once, so a late pin cannot flip them
            next_q.in_use  = use_now;
            next_q.shorted = 6'h00;
            if (!uvp_ok) begin
              next_q.uvp_latch = 1'b1;
              next_q.state     = led_seq_pkg::ST_LATCHED;
            end else begin
              next_q.short_fault = 1'b0;
              next_q.ss_cnt      = '0;
              next_q.state       = led_seq_pkg::ST_SOFTSTART;
            end
          end
        end
      end
      led_seq_pkg::ST_SOFTSTART: begin
        next_q.ss_cnt = sat_inc(q.ss_cnt, SS_TIME);
        if (pin_fault) begin
          next_q.short_fault = 1'b1;
          next_q.det_cnt     = '0;
          next_q.state       = led_seq_pkg::ST_DETECT;
        end else if ((((q.in_use & in_reg) == q.in_use) &&
                      (q.in_use != 6'h00)) || v93 ||
                     (q.ss_cnt == SS_TIME)) begin
          next_q.state = led_seq_pkg::ST_RUN;
        end
      end
      led_seq_pkg::ST_RUN: begin
        if (!uvp_ok) begin
          next_q.uvp_latch = 1'b1;
          next_q.state     = led_seq_pkg::ST_LATCHED;
        end else if (pin_fault) begin
          next_q.short_fault = 1'b1;
          next_q.det_cnt     = '0;
          next_q.state       = led_seq_pkg::ST_DETECT;
        end
      end
      led_seq_pkg::ST_LATCHED: begin
        // Stays off until the latch is cleared, then rewakes from off
        // Gate, reference, boost and sinks are off here; only the fault line stays pulled
        if (!q.uvp_latch) begin
          next_q.state = led_seq_pkg::ST_OFF;
        end
      end
      default: begin
        next_q.state = led_seq_pkg::ST_OFF;
      end
    endcase

    // complete shutdown
    // Kept awake only when software sets the keep bit; then the latch clears and active states fall back to wait-dim
    // Classes are dropped so the next wake repeats detection
    if (!supply || (long_low && !q.keep_awake) || !q.ctrl_enable) begin
      next_q.state       = led_seq_pkg::ST_OFF;
      next_q.short_fault = 1'b0;
      next_q.in_use      = 6'h00;
      next_q.shorted     = 6'h00;
    end else if (long_low && (q.state != led_seq_pkg::ST_LATCHED)) begin
      next_q.state = (q.state == led_seq_pkg::ST_OFF) ?
                     led_seq_pkg::ST_OFF : led_seq_pkg::ST_WAIT_DIM;
    end

    // Output drive from the next state
    running = is_ramp(next_q.state) ||
              (next_q.state == led_seq_pkg::ST_RUN);
    next_q.gate_pull = (next_q.state != led_seq_pkg::ST_OFF) &&
                       (next_q.state != led_seq_pkg::ST_LATCHED);
    next_q.current_reference_pin_en   = next_q.gate_pull &&
                       (next_q.state != led_seq_pkg::ST_GATE);
    // boost on dimming high
    // Soft-start ramps regardless of duty so startup time stays fixed
    next_q.boost_en  = is_ramp(next_q.state) ||
                       ((next_q.state == led_seq_pkg::ST_RUN) && en);
    // Ramp flag registered with the state so the pin comes from a flop
    next_q.ss_on     = is_ramp(next_q.state);
    // Sinks stay dark outside the ramp and run states
    // sinks follow dimming
    next_q.sink_en   = running ? (next_q.in_use & {6{en}}) : 6'h00;
    next_q.fault_oe  = next_q.uvp_latch || next_q.short_fault;
  end

  // ==========================================================================
  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= led_seq_pkg::SEQ_RESET;
    end else begin
      q <= next_q;
    end
  end

endmodule

// file: dv/led_host_model.sv
/*
  Host model: drives the enable/dimming pin, resolves the fault line.
  Assumes the sequencer pulls the fault line low through fault_oe.
*/
`timescale 1ns/10ps
module led_host_model (
  input  wire logic hclk,
  input  wire logic fault_oe,
  output logic      en_dim_pin,
  output logic      fault_in
);
  // ==========================================
  // Pin levels
  // Pulled-up open-drain line, high once released
  assign fault_in = fault_oe ? 1'b0 : 1'b1;

  // Enable held high from power-up
  initial begin
    en_dim_pin = 1'b1;
  end

  // low period length
  // Dimming lows stay short; long lows are a deliberate power cycle
  task automatic dim_low(input int n);
    @(posedge hclk);
    en_dim_pin <= 1'b0;
    repeat (n) @(posedge hclk);
    en_dim_pin <= 1'b1;
  endtask
endmodule

// file: dv/led_seq_sva.sv
/*
  Checker for the LED startup sequencer, bound to its top module.
  Assumes host inputs stay steady for several cycles around each step.
*/
`timescale 1ns/10ps
module led_seq_sva #(
  parameter logic [19:0] OFF_CYCLES = 20'h000c8,
  parameter logic [19:0] SS_TIME    = 20'h0012c
) (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       en_dim_pin,
  input wire logic       supply_above_lockout,
  input wire logic       vout_above_uvp,
  input wire logic       frequency_program_pin_fault,
  input wire logic       current_reference_pin_fault,
  input wire logic [5:0] led_above_short,
  input wire logic       fault_oe,
  input wire logic       gate_pull_en,
  input wire logic       boost_en,
  input wire logic [5:0] sink_en,
  input wire logic [5:0] channel_in_loop,
  input wire logic       softstart_active
);
  logic [19:0] low_run;
  logic [19:0] ss_run;

  // ==========================================
  // Run lengths
  // Counters, since the timers are far too long to unroll
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_run <= '0;
      ss_run  <= '0;
    end else begin
      low_run <= en_dim_pin ? 20'h00000 : low_run + 20'h00001;
      ss_run  <= softstart_active ? ss_run + 20'h00001 : 20'h00000;
    end
  end

  // ==========================================
  // Properties
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_wake;
    $rose(gate_pull_en) && en_dim_pin |->
      $past(en_dim_pin, 4) && $past(supply_above_lockout, 4);
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake without enable and supply");

  property p_low_off;
    low_run > OFF_CYCLES + 20'h00008 |-> !softstart_active && !boost_en;
  endproperty
  a_low_off: assert property (p_low_off)
    else $error("still active after long low");

  property p_sink_low;
    low_run >= 20'h0000a |-> sink_en == 6'h00;
  endproperty
  a_sink_low: assert property (p_sink_low)
    else $error("sinks on while dimming low");

  property p_unused;
    (sink_en & ~channel_in_loop) == 6'h00;
  endproperty
  a_unused: assert property (p_unused)
    else $error("sink on outside regulation loop");

  property p_ss_ok;
    $rose(softstart_active) |-> &led_above_short &&
      !frequency_program_pin_fault && !current_reference_pin_fault;
  endproperty
  a_ss_ok: assert property (p_ss_ok)
    else $error("soft-start with pin short");

  property p_ss_uvp;
    $rose(softstart_active) |-> vout_above_uvp && $past(vout_above_uvp, 4);
  endproperty
  a_ss_uvp: assert property (p_ss_uvp)
    else $error("soft-start with output low");

  property p_ss_len;
    ss_run <= SS_TIME + 20'h00003;
  endproperty
  a_ss_len: assert property (p_ss_len)
    else $error("soft-start overran its timer");

  property p_uvp_off;
    !vout_above_uvp [*8] |-> !boost_en && sink_en == 6'h00;
  endproperty
  a_uvp_off: assert property (p_uvp_off)
    else $error("running with output undervoltage");

  // Main scenarios reached
  c_ss: cover property ($rose(softstart_active));
  c_fault: cover property ($rose(fault_oe));
  c_dim: cover property ($fell(en_dim_pin) && boost_en);
endmodule

bind led_startup_sequencer led_seq_sva #(
  .OFF_CYCLES(OFF_CYCLES),
  .SS_TIME   (SS_TIME)
) u_sva (
  .hclk, .hresetn, .en_dim_pin, .supply_above_lockout, .vout_above_uvp,
  .frequency_program_pin_fault, .current_reference_pin_fault,
  .led_above_short, .fault_oe, .gate_pull_en, .boost_en, .sink_en,
  .channel_in_loop, .softstart_active
);

// file: dv/led_startup_sequencer_test.sv
/*
  Testbench: AHB-Lite register access, comparator stimulus, host model.
  Assumes shortened timers so the run stays brief.
*/
`timescale 1ns/10ps
module led_startup_sequencer_test;
  localparam logic [19:0] SS = 20'h0012c;
  logic hclk, hresetn, hsel, hwrite, hrdy, supply, vout_ok;
  logic fpf, crf, en, flt, foe, gpe, cre, boost, ss_on, gate, abc;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [5:0]  las, liu, lir, sinks, in_loop;
  int          miscompares, samples_checked, n;

  led_startup_sequencer #(.OFF_CYCLES(20'h000c8), .DETECT_TIME(20'h00032),
    .SS_TIME(SS)) u_dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hrdy), .hreadyout(hrdy), .hrdata, .hresp(),
    .en_dim_pin(en), .supply_above_lockout(supply),
    .gate_at_threshold(gate), .vout_above_uvp(vout_ok),
    .vout_above_93pct(1'b0), .frequency_program_pin_fault(fpf),
    .current_reference_pin_fault(crf), .led_above_short(las),
    .led_in_use(liu), .led_in_regulation(lir), .fault_in(flt),
    .fault_out(), .fault_oe(foe), .gate_pull_en(gpe),
    .current_reference_en(cre), .boost_en(boost), .sink_en(sinks),
    .channel_in_loop(in_loop), .anticipatory_boost_control(abc),
    .softstart_active(ss_on)
  );
  led_host_model u_host (
    .hclk, .fault_oe(foe), .en_dim_pin(en), .fault_in(flt)
  );

  // ==========================================
  // Clock
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  // ==========================================
  // Tasks
  task automatic wrap_up;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask

  // One single transfer; the slave's readiness is awaited, not assumed
  task automatic bus(logic w, logic [7:0] a, logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'b10;
    hsize  <= 3'h2;
    @(posedge hclk);
    while (hrdy !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hrdy !== 1'b1) @(posedge hclk);
    d = hrdata;
  endtask

  // Settle past the edge so flop updates have landed
  task automatic tk(int c);
    repeat (c) @(posedge hclk);
    #1;
  endtask

  // Bounded wait for an output level
  task automatic wt(int k, logic v);
    int i;
    i = 0;
    while ((k == 0 ? gpe : k == 1 ? foe : ss_on) !== v && i < 1000) begin
      tk(1);
      i++;
    end
    chk($sformatf("wait%0d", k), 32'(v), 32'(i < 1000 ? v : ~v));
    #1;
  endtask

  // ==========================================
  // Tests
  initial begin
    {miscompares, samples_checked} = '0;
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, hsize} = '0;
    {supply, fpf, crf, lir, gate} = '0;
    vout_ok = 1'b1;
    las = 6'h3f;
    liu = 6'h3b;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 8'h00, 32'h0);
    chk("ctrl", 32'h00000001, d);
    bus(1'b0, 8'h08, 32'h0);
    chk("status", 32'h00000080, d);
    bus(1'b1, 8'h04, 32'h00001234);
    bus(1'b0, 8'h04, 32'h0);
    chk("config", 32'h00001234, d);
    bus(1'b1, 8'h04, 32'h00000064);
    bus(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, d);
    tk(20);
    chk("no_wake", 32'h0, gpe);
    @(posedge hclk);
    supply <= 1'b1;
    wt(0, 1'b1);
    chk("iref_off", 32'h0, cre);
    @(posedge hclk);
    gate <= 1'b1;
    // One LED short, then each program pin fault, back to back
    for (int k = 0; k < 3; k++) begin
      @(posedge hclk);
      las <= (k == 0) ? 6'h3e : 6'h3f;
      fpf <= (k == 1);
      crf <= (k == 2);
      tk(80);
      chk("fault_oe", 32'h1, foe);
      chk("ss_held", 32'h0, ss_on);
    end
    chk("iref_on", 32'h1, cre);
    @(posedge hclk);
    {fpf, crf} <= 2'b00;
    wt(2, 1'b1);
    tk(2);
    chk("fault_rel", 32'h0, foe);
    chk("in_loop", 32'h3b, in_loop);
    chk("sinks", 32'h3b, sinks);
    chk("boost", 32'h1, boost);
    @(posedge hclk);
    lir <= 6'h3b;
    wt(2, 1'b0);
    bus(1'b0, 8'h08, 32'h0);
    chk("run", 32'h5, d & 32'h7);
    fork
      u_host.dim_low(20);
      begin
        tk(15);
        chk("dim_off", 32'h0, sinks);
      end
    join
    tk(8);
    chk("dim_on", 32'h3b, sinks);
    chk("closed_loop", 32'h0, abc);
    @(posedge hclk);
    lir <= 6'h00;
    fork
      u_host.dim_low(230);
      begin
        tk(220);
        chk("off", 32'h0, gpe);
      end
    join
    chk("open_loop", 32'h1, abc);
    wt(2, 1'b1);
    n = 0;
    while (ss_on === 1'b1 && n < 1000) begin
      tk(1);
      n++;
    end
    chk("ss_time", 32'h1, 32'(n > int'(SS) - 5 && n < int'(SS) + 5));
    @(posedge hclk);
    vout_ok <= 1'b0;
    wt(1, 1'b1);
    tk(10);
    chk("uvp_boost", 32'h0, boost);
    bus(1'b0, 8'h08, 32'h0);
    chk("latch", 32'h10, d & 32'h10);
    @(posedge hclk);
    vout_ok <= 1'b1;
    tk(50);
    chk("stay_off", 32'h0, gpe);
    chk("fault_hold", 32'h1, foe);
    bus(1'b1, 8'h00, 32'h00000003);
    u_host.dim_low(230);
    tk(10);
    chk("unlatch", 32'h0, foe);
    bus(1'b0, 8'h08, 32'h0);
    chk("latch_clr", 32'h0, d & 32'h10);
    wrap_up;
  end

  // Watchdog, well beyond the roughly 1300 cycles the tests need
  initial begin
    repeat (20000) @(posedge hclk);
    miscompares++;
    wrap_up;
  end
endmodule
